//--- hw/dfah_pkg.sv
// Package for the drive fault alarm handler: error table, timing, carriers.
// Assumes a single 100 MHz clock and synchronous active-low reset.
package dfah_pkg;

  // Clock and times in their own units
  localparam int unsigned DFAH_CLK_HZ      = 100_000_000;
  localparam int unsigned DFAH_CLR_TIME_MS = 120;
  localparam int unsigned DFAH_OL_HOLD_S   = 10;
  localparam int unsigned DFAH_CLR_CYC     = DFAH_CLR_TIME_MS * (DFAH_CLK_HZ / 1000);
  localparam int unsigned DFAH_OL_HOLD_CYC = DFAH_OL_HOLD_S * DFAH_CLK_HZ;
  localparam int unsigned DFAH_CNT_W       = 30;

  // Detector count, history depth, overload accumulator width
  localparam int unsigned DFAH_NUM_DET = 17;
  localparam int unsigned DFAH_IDX_W   = 5;
  localparam int unsigned DFAH_HIST_N  = 8;
  localparam int unsigned DFAH_HPTR_W  = 3;
  localparam int unsigned DFAH_OL_W    = 16;

  // Named detector positions used by the logic
  localparam logic [DFAH_IDX_W-1:0] DFAH_IDX_OVERLOAD = 5'h07;
  localparam logic [DFAH_IDX_W-1:0] DFAH_IDX_REGEN_TR = 5'h09;
  localparam logic [DFAH_IDX_W-1:0] DFAH_IDX_OVERTRAV = 5'h0a;
  localparam logic [DFAH_IDX_W-1:0] DFAH_IDX_AIN1     = 5'h0b;
  localparam logic [DFAH_IDX_W-1:0] DFAH_IDX_ABS_DOWN = 5'h0e;

  // Display code as shown on the panel
  typedef struct packed {
    logic [7:0] main_code;
    logic [3:0] sub_code;
  } dfah_code_s;

  // One table entry: code plus attributes
  typedef struct packed {
    dfah_code_s code;
    logic       hist;
    logic       clearable;
    logic       istop;
  } dfah_err_s;

  localparam dfah_code_s DFAH_CODE_NONE = '{main_code: 8'h00, sub_code: 4'h0};

  // Codes are decimal main numbers; bit order is detector index
  localparam dfah_err_s DFAH_ERR_TAB [DFAH_NUM_DET] = '{
    '{'{8'd11, 4'd0}, 1'b0, 1'b0, 1'b0},  // Control supply undervoltage
    '{'{8'd12, 4'd0}, 1'b1, 1'b1, 1'b0},  // Overvoltage
    '{'{8'd13, 4'd0}, 1'b0, 1'b0, 1'b0},  // Main supply undervoltage
    '{'{8'd13, 4'd1}, 1'b0, 1'b1, 1'b0},  // AC interruption
    '{'{8'd14, 4'd0}, 1'b1, 1'b0, 1'b0},  // Overcurrent
    '{'{8'd14, 4'd1}, 1'b1, 1'b0, 1'b0},  // Power module error
    '{'{8'd15, 4'd0}, 1'b1, 1'b0, 1'b1},  // Overheat
    '{'{8'd16, 4'd0}, 1'b1, 1'b1, 1'b0},  // Overload
    '{'{8'd18, 4'd0}, 1'b1, 1'b0, 1'b1},  // Regeneration load
    '{'{8'd18, 4'd1}, 1'b1, 1'b0, 1'b0},  // Regeneration transistor
    '{'{8'd38, 4'd0}, 1'b0, 1'b1, 1'b0},  // Overtravel inhibit
    '{'{8'd39, 4'd0}, 1'b1, 1'b1, 1'b1},  // Analog input 1 excess
    '{'{8'd39, 4'd1}, 1'b1, 1'b1, 1'b1},  // Analog input 2 excess
    '{'{8'd39, 4'd2}, 1'b1, 1'b1, 1'b1},  // Analog input 3 excess
    '{'{8'd40, 4'd0}, 1'b1, 1'b1, 1'b0},  // Absolute system down
    '{'{8'd41, 4'd0}, 1'b1, 1'b0, 1'b0},  // Absolute counter overflow
    '{'{8'd42, 4'd0}, 1'b1, 1'b1, 1'b0}   // Absolute overspeed
  };

  // Alarm sequence choice
  typedef enum logic [0:0] {
    DFAH_SEQ_FREE  = 1'b0,
    DFAH_SEQ_QSTOP = 1'b1
  } dfah_seq_e;

endpackage

//--- hw/dfah_hold_timer.sv
// Continuous-level qualifier: counts cycles while a level stays high.
// Assumes the level is synchronous to mclk.
`timescale 1ns/1ps

module dfah_hold_timer #(
  parameter int unsigned CW  = 30,
  parameter int unsigned THR = 1
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic lvl,
  output logic      reached,
  output logic      reached_pulse
);

  localparam logic [CW-1:0] THR_C = CW'(THR);

  logic [CW-1:0] cnt_ff;
  logic          reached_d_ff;

  ////////////////////////////////////////////////////////////////////////
  // Restart on any drop, saturate at threshold so it never wraps
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cnt_ff <= '0;
    end else if (!lvl) begin
      cnt_ff <= '0;
    end else if (cnt_ff != THR_C) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // Previous reached level for the one-shot
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reached_d_ff <= 1'b0;
    end else begin
      reached_d_ff <= reached;
    end
  end

  assign reached       = (cnt_ff == THR_C);
  assign reached_pulse = reached && !reached_d_ff; // One pulse per hold

endmodule // dfah_hold_timer

//--- hw/dfah_alarm_handler.sv
// Drive fault supervision: latches errors, stops the motor, opens alarm,
// shows codes, logs history and clears on timed or panel/link command.
// Assumes detector trips and commands are synchronous to mclk.
//
// Operation
// RULE1 - Any trip stops motor, opens alarm output
// RULE2 - Active error code shown on panel display
// RULE3 - Power stage enable refused during error
// RULE4 - Clear input must hold 120 ms first
// RULE5 - Overload clears only 10 s after occurrence; an overload re-latched in its own clearing cycle gets no new hold-off
// RULE6 - Overload accumulator survives clears, reset only
// RULE7 - Panel keys or setup link also clear
// RULE8 - Controller clears only when stopped and safe
// RULE9 - Regen transistor fault is code 18-1
// RULE10 - Overtravel fault is 38-0, clearable
// RULE11 - Analog excess 39-0..2, logged, clearable, stopping
// RULE12 - Absolute encoder faults are 40, 41, 42
// RULE13 - Errors with history attribute get logged
// RULE14 - Immediate stop errors trigger controlled stop
// RULE15 - Clear hold counted, restarting on any drop
`timescale 1ns/1ps

module dfah_alarm_handler
  import dfah_pkg::*;
#(
  parameter int unsigned CLR_CYC     = DFAH_CLR_CYC,
  parameter int unsigned OL_HOLD_CYC = DFAH_OL_HOLD_CYC
) (
  input  wire logic                    mclk,
  input  wire logic                    rst_n,
  input  wire logic [DFAH_NUM_DET-1:0] det_trip,
  input  wire logic                    fault_clear_input,
  input  wire logic                    panel_clear,
  input  wire logic                    link_clear,
  input  wire logic                    servo_on_req,
  input  wire dfah_seq_e               alarm_seq,
  input  wire logic                    ol_heat_inc,
  input  wire logic                    ol_cool_dec,
  input  wire logic [DFAH_HPTR_W-1:0]  hist_sel,
  output logic                         fault_alarm_output,
  output logic                         motor_stop_ff,
  output logic                         qstop_ff,
  output logic                         pwr_stage_en_ff,
  output logic                         err_active_ff,
  output dfah_code_s                   disp_code_ff,
  output dfah_code_s                   hist_rd_ff,
  output logic [DFAH_HPTR_W:0]         hist_cnt_ff,
  output logic [DFAH_OL_W-1:0]         ol_accum_ff
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [DFAH_IDX_W-1:0]  err_idx_ff;
  logic [DFAH_IDX_W-1:0]  nxt_idx;
  logic                   any_trip;
  logic                   latch_go;
  logic                   clr_go;
  logic                   cur_clearable;
  logic                   cur_overload;
  logic                   clr_in_pulse;
  logic                   ol_hold_done;
  dfah_err_s              nxt_ent;
  dfah_code_s             hist_mem [DFAH_HIST_N];
  logic [DFAH_HPTR_W-1:0] hist_wp_ff;

  ////////////////////////////////////////////////////////////////////////
  // Priority pick: lowest index wins when several trip together
  always_comb begin
    nxt_idx = '0;
    for (int i = DFAH_NUM_DET - 1; i >= 0; i--) begin
      if (det_trip[i]) begin
        nxt_idx = DFAH_IDX_W'(i);
      end
    end
  end

  assign any_trip      = |det_trip;
  assign nxt_ent       = DFAH_ERR_TAB[nxt_idx];
  assign cur_clearable = DFAH_ERR_TAB[err_idx_ff].clearable;
  assign cur_overload  = (err_idx_ff == DFAH_IDX_OVERLOAD);

  ////////////////////////////////////////////////////////////////////////
  // Clear input must stay high for the full hold, restarting on a drop
  dfah_hold_timer #(
    .CW  (DFAH_CNT_W),
    .THR (CLR_CYC)
  ) u_clr_timer (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .lvl           (fault_clear_input), // RULE15
    .reached       (),
    .reached_pulse (clr_in_pulse)      // RULE4
  );

  // Overload hold-off runs while the overload error stands, so a re-latch in its own clearing cycle does not restart it
  dfah_hold_timer #(
    .CW  (DFAH_CNT_W),
    .THR (OL_HOLD_CYC)
  ) u_ol_timer (
    .mclk          (mclk),
    .rst_n         (rst_n),
    .lvl           (err_active_ff && cur_overload),
    .reached       (ol_hold_done),
    .reached_pulse ()
  );

  // Timed input or panel/link; non-clearable codes need a power cycle
  always_comb begin
    clr_go = err_active_ff && cur_clearable &&
             (clr_in_pulse || panel_clear || link_clear); // RULE7
    if (cur_overload && !ol_hold_done) begin
      clr_go = 1'b0; // RULE5
    end
  end

  // A trip in the clearing cycle re-latches: set wins over clear
  assign latch_go = any_trip && (!err_active_ff || clr_go);

  ////////////////////////////////////////////////////////////////////////
  // Error state and index
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      err_active_ff <= 1'b0;
      err_idx_ff    <= '0;
    end else if (latch_go) begin
      err_active_ff <= 1'b1; // RULE1
      err_idx_ff    <= nxt_idx;
    end else if (clr_go) begin
      err_active_ff <= 1'b0;
    end
  end

  // Alarm opens (low) while an error stands or a trip is arriving
  assign fault_alarm_output = !(err_active_ff || any_trip); // RULE1

  // Motor stop and controlled stop per alarm sequence setting
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      motor_stop_ff <= 1'b0;
      qstop_ff      <= 1'b0;
    end else if (latch_go) begin
      motor_stop_ff <= 1'b1; // RULE1
      qstop_ff      <= nxt_ent.istop && (alarm_seq == DFAH_SEQ_QSTOP); // RULE14
    end else if (clr_go) begin
      motor_stop_ff <= 1'b0;
      qstop_ff      <= 1'b0;
    end
  end

  // Display follows the latched code; blank when healthy
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      disp_code_ff <= DFAH_CODE_NONE;
    end else if (latch_go) begin
      disp_code_ff <= nxt_ent.code; // RULE2 RULE9 RULE10 RULE11 RULE12
    end else if (clr_go) begin
      disp_code_ff <= DFAH_CODE_NONE;
    end
  end

  // Power stage enable refused while any error is pending
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pwr_stage_en_ff <= 1'b0;
    end else begin
      pwr_stage_en_ff <= servo_on_req && !any_trip &&
                         !(err_active_ff && !clr_go); // RULE3
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // History log; ring of latest entries, kept until power-down
  always_ff @(posedge mclk) begin
    if (latch_go && nxt_ent.hist) begin
      hist_mem[hist_wp_ff] <= nxt_ent.code; // RULE13
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hist_wp_ff  <= '0;
      hist_cnt_ff <= '0;
    end else if (latch_go && nxt_ent.hist) begin
      hist_wp_ff <= hist_wp_ff + 1'b1; // RULE13
      if (hist_cnt_ff != (DFAH_HPTR_W+1)'(DFAH_HIST_N)) begin
        hist_cnt_ff <= hist_cnt_ff + 1'b1;
      end
    end
  end

  // Readout: 0 is the newest; empty slots read as no code
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hist_rd_ff <= DFAH_CODE_NONE;
    end else if ({1'b0, hist_sel} < hist_cnt_ff) begin
      hist_rd_ff <= hist_mem[hist_wp_ff - hist_sel - 1'b1];
    end else begin
      hist_rd_ff <= DFAH_CODE_NONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Overload characteristic; clears only with control power
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ol_accum_ff <= '0; // RULE6
    end else if (ol_heat_inc && !ol_cool_dec && (ol_accum_ff != '1)) begin
      ol_accum_ff <= ol_accum_ff + 1'b1;
    end else if (ol_cool_dec && !ol_heat_inc && (ol_accum_ff != '0)) begin
      ol_accum_ff <= ol_accum_ff - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks; helper counts consecutive clear-input cycles
  logic [DFAH_CNT_W-1:0] chk_hi_cnt_ff;

  always_ff @(posedge mclk) begin
    if (!rst_n || !fault_clear_input) begin
      chk_hi_cnt_ff <= '0;
    end else if (chk_hi_cnt_ff != '1) begin
      chk_hi_cnt_ff <= chk_hi_cnt_ff + 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_trip_opens;
    any_trip && !err_active_ff |=> err_active_ff && motor_stop_ff && !fault_alarm_output;
  endproperty
  a_trip_opens: assert property (p_trip_opens) // RULE1
    else $error("trip did not stop motor and open alarm");

  property p_disp_code;
    err_active_ff |-> disp_code_ff == DFAH_ERR_TAB[err_idx_ff].code;
  endproperty
  a_disp_code: assert property (p_disp_code) // RULE2
    else $error("display does not show active code");

  property p_no_enable;
    err_active_ff ##1 err_active_ff |-> !pwr_stage_en_ff;
  endproperty
  a_no_enable: assert property (p_no_enable) // RULE3
    else $error("power stage enabled during error");

  property p_clr_hold;
    clr_in_pulse |-> $past(fault_clear_input)
                     && (chk_hi_cnt_ff == DFAH_CNT_W'(CLR_CYC));
  endproperty
  fault_clear_input_hold: assert property (p_clr_hold) // RULE4 RULE15
    else $error("clear accepted before hold time");

  property p_ol_holdoff;
    err_active_ff && cur_overload && !ol_hold_done |=> err_active_ff;
  endproperty
  a_ol_holdoff: assert property (p_ol_holdoff) // RULE5
    else $error("overload cleared inside hold-off");

  property p_ol_keep;
    clr_go && !ol_heat_inc && !ol_cool_dec |=> $stable(ol_accum_ff);
  endproperty
  a_ol_keep: assert property (p_ol_keep) // RULE6
    else $error("overload state changed by clear");

  property p_panel_clr;
    err_active_ff && cur_clearable && !cur_overload && panel_clear && !any_trip
      |=> !err_active_ff ##1 !motor_stop_ff || err_active_ff;
  endproperty
  a_panel_clr: assert property (p_panel_clr) // RULE7
    else $error("panel clear not taken");

  property p_no_clear;
    err_active_ff && !cur_clearable |=> err_active_ff && $stable(err_idx_ff);
  endproperty
  a_no_clear: assert property (p_no_clear) // RULE10 RULE11
    else $error("non-clearable error was cleared");

  property p_codes;
    latch_go && (nxt_idx == DFAH_IDX_REGEN_TR || nxt_idx == DFAH_IDX_OVERTRAV
                 || nxt_idx == DFAH_IDX_AIN1 || nxt_idx == DFAH_IDX_ABS_DOWN)
      |=> disp_code_ff.main_code inside {8'd18, 8'd38, 8'd39, 8'd40}
          && disp_code_ff.sub_code == ((err_idx_ff == DFAH_IDX_REGEN_TR) ? 4'h1 : 4'h0);
  endproperty
  a_codes: assert property (p_codes) // RULE9 RULE10 RULE11 RULE12
    else $error("wrong code for detector");

  property p_hist_log;
    latch_go && nxt_ent.hist && hist_cnt_ff == '0 |=> hist_cnt_ff == 4'h1
      ##1 (hist_sel != '0 || hist_rd_ff == disp_code_ff || !err_active_ff);
  endproperty
  a_hist_log: assert property (p_hist_log) // RULE13
    else $error("history entry not recorded");

  property p_qstop;
    latch_go && nxt_ent.istop && alarm_seq == DFAH_SEQ_QSTOP |=> qstop_ff && motor_stop_ff;
  endproperty
  a_qstop: assert property (p_qstop) // RULE14
    else $error("immediate stop not issued");

  property p_first_kept;
    err_active_ff && !clr_go |=> err_active_ff && $stable(disp_code_ff);
  endproperty
  a_first_kept: assert property (p_first_kept) // RULE2
    else $error("standing error code replaced");

endmodule // dfah_alarm_handler

//--- tb/dfah_host_model.sv
// Host controller model: timed clear hold and power stage enable request.
// Assumes it shares mclk and rst_n with the alarm handler.
`timescale 1ns/1ps

module dfah_host_model (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       motor_stop_ff,
  input  wire logic       hold_start,
  input  wire logic [7:0] hold_len,
  input  wire logic       servo_want,
  output logic            fault_clear_input,
  output logic            servo_on_req,
  output logic            busy
);
  logic [7:0] hold_cnt_ff;

  // Clear is only issued with the motor stopped; short holds are the bench's choice
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hold_cnt_ff <= 8'h00;
    end else if (hold_start && motor_stop_ff && hold_cnt_ff == 8'h00) begin
      hold_cnt_ff <= hold_len;
    end else if (hold_cnt_ff != 8'h00) begin
      hold_cnt_ff <= hold_cnt_ff - 8'h01;
    end
  end

  // One unbroken level, so the handler sees a single hold
  assign fault_clear_input = (hold_cnt_ff != 8'h00);
  assign busy              = fault_clear_input;

  // Enable request follows the bench one flop late
  always_ff @(posedge mclk) begin
    if (!rst_n) servo_on_req <= 1'b0;
    else servo_on_req <= servo_want;
  end
endmodule // dfah_host_model

//--- tb/tb_top.sv
// Self-checking bench for the drive fault alarm handler.
// Assumes shortened clear and overload hold-off counts set below.
`timescale 1ns/1ps

module tb_top;
  import dfah_pkg::*;
  localparam int unsigned CLR = 20;
  localparam int unsigned OLH = 50;
  logic                    mclk = 1'b0;
  logic                    rst_n = 1'b0;
  logic [DFAH_NUM_DET-1:0] det_trip = '0;
  logic                    panel_clear = 1'b0;
  logic                    link_clear = 1'b0;
  dfah_seq_e               alarm_seq = DFAH_SEQ_QSTOP;
  logic                    ol_heat_inc = 1'b0;
  logic                    ol_cool_dec = 1'b0;
  logic [DFAH_HPTR_W-1:0]  hist_sel = '0;
  logic                    hold_start = 1'b0;
  logic [7:0]              hold_len = 8'h00;
  logic                    servo_want = 1'b1;
  logic                    fault_clear_input, servo_on_req, busy;
  logic                    fault_alarm_output, motor_stop_ff, qstop_ff, pwr_stage_en_ff;
  logic                    err_active_ff;
  dfah_code_s              disp_code_ff, hist_rd_ff;
  logic [DFAH_HPTR_W:0]    hist_cnt_ff;
  logic [DFAH_OL_W-1:0]    ol_accum_ff;
  int                      miscompares = 0;
  int                      num_checks = 0;
  // Per detector: main, sub, history, clearable, immediate stop
  logic [14:0] exp_tab [17] = '{
    {8'd11, 4'd0, 3'b000}, {8'd12, 4'd0, 3'b110}, {8'd13, 4'd0, 3'b000},
    {8'd13, 4'd1, 3'b010}, {8'd14, 4'd0, 3'b100}, {8'd14, 4'd1, 3'b100},
    {8'd15, 4'd0, 3'b101}, {8'd16, 4'd0, 3'b110}, {8'd18, 4'd0, 3'b101},
    {8'd18, 4'd1, 3'b100}, {8'd38, 4'd0, 3'b010}, {8'd39, 4'd0, 3'b111},
    {8'd39, 4'd1, 3'b111}, {8'd39, 4'd2, 3'b111}, {8'd40, 4'd0, 3'b110},
    {8'd41, 4'd0, 3'b100}, {8'd42, 4'd0, 3'b110}};

  always #5 mclk = ~mclk;

  dfah_alarm_handler #(.CLR_CYC(CLR), .OL_HOLD_CYC(OLH)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .det_trip(det_trip),
    .fault_clear_input(fault_clear_input), .panel_clear(panel_clear),
    .link_clear(link_clear), .servo_on_req(servo_on_req), .alarm_seq(alarm_seq),
    .ol_heat_inc(ol_heat_inc), .ol_cool_dec(ol_cool_dec), .hist_sel(hist_sel),
    .fault_alarm_output(fault_alarm_output), .motor_stop_ff(motor_stop_ff),
    .qstop_ff(qstop_ff), .pwr_stage_en_ff(pwr_stage_en_ff),
    .err_active_ff(err_active_ff), .disp_code_ff(disp_code_ff),
    .hist_rd_ff(hist_rd_ff), .hist_cnt_ff(hist_cnt_ff), .ol_accum_ff(ol_accum_ff));

  dfah_host_model u_host (
    .mclk(mclk), .rst_n(rst_n), .motor_stop_ff(motor_stop_ff),
    .hold_start(hold_start), .hold_len(hold_len), .servo_want(servo_want),
    .fault_clear_input(fault_clear_input), .servo_on_req(servo_on_req), .busy(busy));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Reset held six cycles, as a control power cycle
  task automatic do_reset();
    @(posedge mclk) rst_n <= 1'b0;
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic hold_clr(input int n);
    @(posedge mclk) hold_start <= 1'b1;
    hold_len <= 8'(n);
    @(posedge mclk) hold_start <= 1'b0;
    repeat (n + 4) @(posedge mclk);
    #1;
  endtask

  task automatic pulse_clr(input logic use_link);
    @(posedge mclk) panel_clear <= !use_link;
    link_clear <= use_link;
    @(posedge mclk) panel_clear <= 1'b0;
    link_clear <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic trip_one(input int i);
    @(posedge mclk) det_trip <= 17'h00001 << i;
    @(posedge mclk) det_trip <= '0;
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Every detector: code, attributes, refusal of a later trip, clear path
  task automatic t_trip(input int i);
    logic [14:0] e;
    logic        sq;
    e  = exp_tab[i];
    sq = (i % 2) == 0;
    @(posedge mclk) alarm_seq <= sq ? DFAH_SEQ_QSTOP : DFAH_SEQ_FREE;
    do_reset();
    chk("healthy_alarm", 16'(fault_alarm_output), 16'h0001);
    chk("healthy_disp", 16'(disp_code_ff), 16'h0000);
    chk("healthy_pwr", 16'(pwr_stage_en_ff), 16'h0001);
    @(posedge mclk) det_trip <= 17'h00001 << i;
    #1 chk("alarm_now", 16'(fault_alarm_output), 16'h0000);
    @(posedge mclk) det_trip <= 17'h00001 << ((i + 1) % 17);
    #1 chk("stop", 16'(motor_stop_ff), 16'h0001);
    chk("disp", 16'(disp_code_ff), 16'(e[14:3]));
    chk("qstop", 16'(qstop_ff), 16'(e[0] & sq));
    chk("hist_cnt", 16'(hist_cnt_ff), 16'(e[2]));
    @(posedge mclk) det_trip <= '0;
    repeat (2) @(posedge mclk);
    #1 chk("disp_kept", 16'(disp_code_ff), 16'(e[14:3]));
    chk("pwr_off", 16'(pwr_stage_en_ff), 16'h0000);
    chk("hist_rd", 16'(hist_rd_ff), e[2] ? 16'(e[14:3]) : 16'h0000);
    if (i == 7) begin
      pulse_clr(1'b0);
      chk("ol_early", 16'(err_active_ff), 16'h0001);
      repeat (OLH) @(posedge mclk);
    end
    pulse_clr(i[0]);
    chk("cleared", 16'(err_active_ff), 16'(!e[1]));
    chk("alarm_back", 16'(fault_alarm_output), 16'(e[1]));
    chk("disp_back", 16'(disp_code_ff), e[1] ? 16'h0000 : 16'(e[14:3]));
    repeat (2) @(posedge mclk);
    #1 chk("pwr_back", 16'(pwr_stage_en_ff), 16'(e[1]));
  endtask

  // Timed clear on the overtravel fault: short holds restart, full hold clears
  task automatic t_timed();
    do_reset();
    trip_one(10);
    hold_clr(CLR - 1);
    chk("short_hold", 16'(err_active_ff), 16'h0001);
    hold_clr(CLR - 1);
    chk("restart", 16'(err_active_ff), 16'h0001);
    hold_clr(CLR + 1);
    chk("full_hold", 16'(err_active_ff), 16'h0000);
    chk("host_idle", 16'(busy), 16'h0000);
  endtask

  // Overload: hold-off on timed clear, accumulator survives clears, cleared by reset
  task automatic t_overload();
    do_reset();
    @(posedge mclk) ol_heat_inc <= 1'b1;
    repeat (3) @(posedge mclk);
    ol_heat_inc <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("ol_up", 16'(ol_accum_ff), 16'h0003);
    trip_one(7);
    hold_clr(CLR + 1);
    chk("ol_holdoff", 16'(err_active_ff), 16'h0001);
    repeat (OLH) @(posedge mclk);
    hold_clr(CLR + 1);
    chk("ol_clear", 16'(err_active_ff), 16'h0000);
    chk("ol_kept", 16'(ol_accum_ff), 16'h0003);
    @(posedge mclk) ol_cool_dec <= 1'b1;
    @(posedge mclk) ol_cool_dec <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk("ol_down", 16'(ol_accum_ff), 16'h0002);
    do_reset();
    chk("ol_power", 16'(ol_accum_ff), 16'h0000);
  endtask

  // Two trips at once, history by slot, enable follows the request
  task automatic t_hist();
    do_reset();
    @(posedge mclk) det_trip <= 17'h00802;
    @(posedge mclk) det_trip <= '0;
    #1 chk("prio", 16'(disp_code_ff), 16'(exp_tab[1][14:3]));
    pulse_clr(1'b0);
    trip_one(11);
    pulse_clr(1'b1);
    @(posedge mclk) hist_sel <= 3'h1;
    servo_want <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk("hist_old", 16'(hist_rd_ff), 16'(exp_tab[1][14:3]));
    chk("hist_n", 16'(hist_cnt_ff), 16'h0002);
    chk("pwr_req", 16'(pwr_stage_en_ff), 16'h0000);
    @(posedge mclk) hist_sel <= 3'h2;
    repeat (2) @(posedge mclk);
    #1 chk("hist_empty", 16'(hist_rd_ff), 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int i = 0; i < 17; i++) begin
      t_trip(i);
    end
    t_timed();
    t_overload();
    t_hist();
    end_sim();
  end

  // Hang guard at 20000 cycles, far beyond the several hundred cycles the run needs
  initial begin
    #200us;
    miscompares++;
    end_sim();
  end
endmodule // tb_top
